/* verilog/fpms_regs.vh */
// register offsets, field positions and timing constants of the flash program/margin sequencer
`ifndef FPMS_REGS_VH
`define FPMS_REGS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FPMS_CTRL_OFF      8'h00
`define FPMS_PROTECT_OFF   8'h04
`define FPMS_ADDR_OFF      8'h08
`define FPMS_DATA_OFF      8'h0c
`define FPMS_STATUS_OFF    8'h10
`define FPMS_LATCH_LO_OFF  8'h14
`define FPMS_LATCH_HI_OFF  8'h18
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define FPMS_CTRL_PGM      0
`define FPMS_CTRL_ERASE    1
`define FPMS_CTRL_MARGIN   2
`define FPMS_CTRL_HV       3
// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define FPMS_ST_PROT_READ  0
`define FPMS_ST_PUMP       1
`define FPMS_ST_BLOCKED    2
`define FPMS_ST_STANDBY    3
`define FPMS_ST_BUSY       4
`define FPMS_ST_WR_COUNT   8
// ---------------------------------------------------------------
// constants
// ---------------------------------------------------------------
`define FPMS_MARGIN_STRETCH 4'h8
`define FPMS_PAGE_BYTES     4'h8
`define FPMS_ERASED_BYTE    8'h00
`define FPMS_AXI_OKAY       2'b00
`define FPMS_AXI_SLVERR     2'b10
`endif

/* verilog/fpms_top.v */
// flash program, margin-read and block-protect sequencer with an axi4-lite register port
// Operation
// - erased byte reads as zero
// - program one aligned eight-byte page
// - margin read stretched by eight cycles
// - watchdog keeps counting during stretch
// - margin read only after page program
// - program select latches following array writes
// - steps ordered, unrelated accesses tolerated
// - protect read captured for pending check
// - protected range clears program/erase select
// - zero protect byte unlocks everything
// - protect byte changes need elevated voltage
// - wait mode stops pump, bits kept
// - stop mode stops pump, standby when no select is set
// - high voltage only after proper steps
// - margin cannot set while high voltage
// - program and erase select exclusive
// - programmed bit one, erased zero
`include "fpms_regs.vh"
module fpms_top #(
  parameter ADDR_W = 15
) (
  // clock and reset
  input  wire        MCLK_IN,
  input  wire        SRST_IN,
  // axi4-lite write address and data
  input  wire [7:0]  AWADDR_IN,
  input  wire        AWVALID_IN,
  output wire        AWREADY_OUT,
  input  wire [31:0] WDATA_IN,
  input  wire [3:0]  WSTRB_IN,
  input  wire        WVALID_IN,
  output wire        WREADY_OUT,
  // axi4-lite write response
  output reg  [1:0]  BRESP_OUT,
  output reg         BVALID_OUT,
  input  wire        BREADY_IN,
  // axi4-lite read
  input  wire [7:0]  ARADDR_IN,
  input  wire        ARVALID_IN,
  output wire        ARREADY_OUT,
  output reg  [31:0] RDATA_OUT,
  output reg  [1:0]  RRESP_OUT,
  output reg         RVALID_OUT,
  input  wire        RREADY_IN,
  // low-power requests and protect voltage pin
  input  wire        WAIT_MODE_IN,
  input  wire        STOP_MODE_IN,
  input  wire        ELEVATED_TEST_VOLTAGE_IN,
  // protect byte as held in nonvolatile storage
  input  wire [7:0]  PROTECT_NV_IN,
  // array port
  output reg  [ADDR_W-1:0] ARRAY_ADDR_OUT,
  output reg  [63:0] ARRAY_PAGE_OUT,
  output reg         ARRAY_PROGRAM_OUT,
  output reg         ARRAY_MARGIN_OUT,
  output reg         ARRAY_READ_OUT,
  input  wire [7:0]  ARRAY_RDATA_IN,
  output reg         PROTECT_WRITE_OUT,
  output reg  [7:0]  PROTECT_WDATA_OUT,
  // charge pump, standby and watchdog
  output wire        CHARGE_PUMP_ON_OUT,
  output wire        STANDBY_OUT,
  output wire        WATCHDOG_TICK_OUT
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_RESP = 2'b10;

  reg              program_select;
  reg              erase_select;
  reg              high_voltage_on;
  reg              margin;
  reg              protect_read;
  reg  [7:0]       protect_latch;
  reg              blocked;
  reg              page_programmed;
  reg  [3:0]       wr_count;
  reg  [ADDR_W-1:0] target_addr;
  reg  [ADDR_W-1:0] addr_reg;
  reg  [7:0]       page [0:7];
  reg  [1:0]       rd_state;
  reg  [3:0]       stretch;
  reg  [7:0]       rd_off;
  reg  [1:0]       s_wait;
  reg  [1:0]       s_stop;
  reg  [1:0]       s_vhi;
  reg  [7:0]       s_nv0;
  reg  [7:0]       s_nv;
  reg              aw_held;
  reg              w_held;
  reg  [7:0]       aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  integer          i;

  wire wait_mode = s_wait[1];
  wire stop_mode = s_stop[1];
  wire vhi       = s_vhi[1];

  // protect bit k locks one eighth of the address space
  function fpms_locked;
    input [7:0]        prot;
    input [ADDR_W-1:0] a;
    begin
      fpms_locked = prot[a[ADDR_W-1 -: 3]];
    end
  endfunction

  // ---------------------------------------------------------------
  // axi4-lite handshakes
  // ---------------------------------------------------------------
  assign AWREADY_OUT = !aw_held && !BVALID_OUT;
  assign WREADY_OUT  = !w_held && !BVALID_OUT;
  assign ARREADY_OUT = (rd_state == ST_IDLE);
  wire do_write = aw_held && w_held && !BVALID_OUT;

  // pump is forced off in low power even though the bits are kept
  assign CHARGE_PUMP_ON_OUT = high_voltage_on && !wait_mode && !stop_mode;
  assign STANDBY_OUT = stop_mode && !program_select && !erase_select;
  // watchdog ticks every clock, stretched cycles included
  assign WATCHDOG_TICK_OUT = 1'b1;

  wire [31:0] ctrl_word = {28'h0, high_voltage_on, margin, erase_select, program_select};
  wire [31:0] status_word = {20'h0, wr_count, 3'h0, (rd_state != ST_IDLE), STANDBY_OUT,
                             blocked, CHARGE_PUMP_ON_OUT, protect_read};

  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= `FPMS_AXI_OKAY;
      program_select  <= 1'b0;
      erase_select    <= 1'b0;
      high_voltage_on <= 1'b0;
      margin          <= 1'b0;
      protect_read    <= 1'b0;
      protect_latch   <= 8'h00;
      blocked         <= 1'b0;
      page_programmed <= 1'b0;
      wr_count        <= 4'h0;
      target_addr     <= {ADDR_W{1'b0}};
      addr_reg        <= {ADDR_W{1'b0}};
      ARRAY_ADDR_OUT  <= {ADDR_W{1'b0}};
      ARRAY_PAGE_OUT  <= 64'h0;
      ARRAY_PROGRAM_OUT <= 1'b0;
      PROTECT_WRITE_OUT <= 1'b0;
      PROTECT_WDATA_OUT <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        page[i] <= `FPMS_ERASED_BYTE;
      end
      s_wait <= 2'b00;
      s_stop <= 2'b00;
      s_vhi  <= 2'b00;
      s_nv0  <= 8'h00;
      s_nv   <= 8'h00;
    end else begin
      s_wait <= {s_wait[0], WAIT_MODE_IN};
      s_stop <= {s_stop[0], STOP_MODE_IN};
      s_vhi  <= {s_vhi[0], ELEVATED_TEST_VOLTAGE_IN};
      s_nv0  <= PROTECT_NV_IN;
      s_nv   <= s_nv0;
      PROTECT_WRITE_OUT <= 1'b0;
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_held <= 1'b1;
        w_data <= WDATA_IN;
        w_strb <= WSTRB_IN;
      end
      if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
      // one-cycle capture of the read of the protect location
      if (ARVALID_IN && ARREADY_OUT && ARADDR_IN == `FPMS_PROTECT_OFF) begin
        protect_latch <= s_nv;
        protect_read  <= program_select || erase_select;
        // a zero byte locks nothing; any set bit over the target clears the select
        if ((program_select || erase_select) && fpms_locked(s_nv, target_addr)) begin
          program_select <= 1'b0;
          erase_select   <= 1'b0;
          blocked        <= 1'b1;
        end
      end
      // reads other than of protect, and writes to address or protect, may fall between sequence steps without disturbing them
      if (do_write) begin
        aw_held    <= 1'b0;
        w_held     <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= `FPMS_AXI_OKAY;
        case (aw_addr)
          `FPMS_CTRL_OFF: begin
            if (w_strb[0]) begin
              // program select and erase select are exclusive; program wins a tie
              if (w_data[`FPMS_CTRL_PGM] && !erase_select) begin
                if (!program_select) begin
                  wr_count        <= 4'h0;
                  protect_read    <= 1'b0;
                  page_programmed <= 1'b0;
                  blocked         <= 1'b0;
                end
                program_select <= 1'b1;
              end else if (!w_data[`FPMS_CTRL_PGM]) begin
                program_select <= 1'b0;
              end
              if (w_data[`FPMS_CTRL_ERASE] && !program_select
                  && !w_data[`FPMS_CTRL_PGM]) begin
                if (!erase_select) begin
                  protect_read <= 1'b0;
                  blocked      <= 1'b0;
                end
                erase_select <= 1'b1;
              end else if (!w_data[`FPMS_CTRL_ERASE]) begin
                erase_select <= 1'b0;
              end
              // high voltage needs a select, a protect read and, for program, a full page
              if (w_data[`FPMS_CTRL_HV]) begin
                if (protect_read && ((program_select && wr_count == `FPMS_PAGE_BYTES)
                    || (erase_select && wr_count != 4'h0))) begin
                  high_voltage_on <= 1'b1;
                  if (program_select) begin
                    ARRAY_PROGRAM_OUT <= 1'b1;
                    ARRAY_ADDR_OUT    <= {target_addr[ADDR_W-1:3], 3'b000};
                    ARRAY_PAGE_OUT    <= {page[7], page[6], page[5], page[4],
                                          page[3], page[2], page[1], page[0]};
                    page_programmed   <= 1'b1;
                  end
                end
              end else begin
                high_voltage_on   <= 1'b0;
                ARRAY_PROGRAM_OUT <= 1'b0;
              end
              // margin is refused while high voltage is on or would turn on
              margin <= w_data[`FPMS_CTRL_MARGIN] && !high_voltage_on
                        && !w_data[`FPMS_CTRL_HV];
            end
          end
          `FPMS_ADDR_OFF: begin
            addr_reg <= w_data[ADDR_W-1:0];
          end
          `FPMS_DATA_OFF: begin
            // while the select is set and high voltage off, writes fill latches only
            if (program_select && !high_voltage_on && wr_count != `FPMS_PAGE_BYTES) begin
              page[addr_reg[2:0]] <= w_data[7:0];
              target_addr <= addr_reg;
              wr_count    <= wr_count + 4'h1;
            end else if (erase_select && !high_voltage_on) begin
              target_addr <= addr_reg;
              wr_count    <= 4'h1;
            end
          end
          `FPMS_PROTECT_OFF: begin
            // the protect byte changes only with the elevated voltage present
            if (vhi) begin
              PROTECT_WRITE_OUT <= 1'b1;
              PROTECT_WDATA_OUT <= w_data[7:0];
            end else begin
              BRESP_OUT <= `FPMS_AXI_SLVERR;
            end
          end
          default: begin
            BRESP_OUT <= `FPMS_AXI_SLVERR;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel with margin stretch
  // ---------------------------------------------------------------
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      rd_state   <= ST_IDLE;
      stretch    <= 4'h0;
      rd_off     <= 8'h00;
      RVALID_OUT <= 1'b0;
      RDATA_OUT  <= 32'h0;
      RRESP_OUT  <= `FPMS_AXI_OKAY;
      ARRAY_READ_OUT   <= 1'b0;
      ARRAY_MARGIN_OUT <= 1'b0;
    end else begin
      ARRAY_MARGIN_OUT <= margin && page_programmed;
      case (rd_state)
        ST_IDLE: begin
          if (ARVALID_IN) begin
            rd_off <= ARADDR_IN;
            // margin only valid after a page program: otherwise a plain read
            stretch <= (ARADDR_IN == `FPMS_DATA_OFF && margin && page_programmed)
                       ? `FPMS_MARGIN_STRETCH : 4'h0;
            ARRAY_READ_OUT <= (ARADDR_IN == `FPMS_DATA_OFF) && !stop_mode;
            rd_state <= ST_READ;
          end
        end
        ST_READ: begin
          // every stretched cycle still ticks the watchdog
          if (stretch != 4'h0) begin
            stretch <= stretch - 4'h1;
          end else begin
            ARRAY_READ_OUT <= 1'b0;
            RVALID_OUT <= 1'b1;
            RRESP_OUT  <= `FPMS_AXI_OKAY;
            case (rd_off)
              `FPMS_CTRL_OFF:     RDATA_OUT <= ctrl_word;
              `FPMS_PROTECT_OFF:  RDATA_OUT <= {24'h0, protect_latch};
              `FPMS_ADDR_OFF:     RDATA_OUT <= {{(32-ADDR_W){1'b0}}, addr_reg};
              // programmed bits read one, erased bits zero
              `FPMS_DATA_OFF:     RDATA_OUT <= {24'h0, ARRAY_RDATA_IN};
              `FPMS_STATUS_OFF:   RDATA_OUT <= status_word;
              `FPMS_LATCH_LO_OFF: RDATA_OUT <= {page[3], page[2], page[1], page[0]};
              `FPMS_LATCH_HI_OFF: RDATA_OUT <= {page[7], page[6], page[5], page[4]};
              default: begin
                RDATA_OUT <= 32'h0;
                RRESP_OUT <= `FPMS_AXI_SLVERR;
              end
            endcase
            rd_state <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (RREADY_IN) begin
            RVALID_OUT <= 1'b0;
            rd_state   <= ST_IDLE;
          end
        end
        default: rd_state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* test/fpms_assertions.sv */
// port-level checker of the flash program/margin sequencer
module fpms_assertions (
  // clock and reset
  input wire logic        MCLK_IN,
  input wire logic        SRST_IN,
  // register bus handshakes
  input wire logic        AWVALID_IN,
  input wire logic        AWREADY_OUT,
  input wire logic        WVALID_IN,
  input wire logic        WREADY_OUT,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic [1:0]  BRESP_OUT,
  input wire logic        ARVALID_IN,
  input wire logic        ARREADY_OUT,
  input wire logic        RVALID_OUT,
  input wire logic        RREADY_IN,
  input wire logic [31:0] RDATA_OUT,
  // low power and protect voltage
  input wire logic        WAIT_MODE_IN,
  input wire logic        STOP_MODE_IN,
  input wire logic        ELEVATED_TEST_VOLTAGE_IN,
  // array side
  input wire logic        ARRAY_PROGRAM_OUT,
  input wire logic        ARRAY_MARGIN_OUT,
  input wire logic        ARRAY_READ_OUT,
  input wire logic        PROTECT_WRITE_OUT,
  input wire logic        CHARGE_PUMP_ON_OUT,
  input wire logic        STANDBY_OUT,
  input wire logic        WATCHDOG_TICK_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  // ---------------------------------------------------------------
  // pump, margin and protect
  // ---------------------------------------------------------------
  AST_TICK: assert property (WATCHDOG_TICK_OUT)
    else $error("watchdog tick dropped");
  // three samples cover the two-flop synchroniser
  AST_WAIT_PUMP: assert property (WAIT_MODE_IN && $past(WAIT_MODE_IN) &&
    $past(WAIT_MODE_IN, 2) |-> !CHARGE_PUMP_ON_OUT)
    else $error("pump on in wait mode");
  AST_STOP_PUMP: assert property (STOP_MODE_IN && $past(STOP_MODE_IN) &&
    $past(STOP_MODE_IN, 2) |-> !CHARGE_PUMP_ON_OUT)
    else $error("pump on in stop mode");
  AST_STANDBY: assert property (STANDBY_OUT |-> !CHARGE_PUMP_ON_OUT && !ARRAY_PROGRAM_OUT)
    else $error("standby with high voltage");
  AST_MARGIN_HV: assert property (ARRAY_MARGIN_OUT |-> !ARRAY_PROGRAM_OUT)
    else $error("margin together with program voltage");
  AST_PROT_WR: assert property (PROTECT_WRITE_OUT |->
    $past(ELEVATED_TEST_VOLTAGE_IN, 3) ##1 !PROTECT_WRITE_OUT)
    else $error("protect byte written without elevated voltage");
  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  AST_BHOLD: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped");
  AST_RHOLD: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read answer dropped");
  AST_RD_LAT: assert property (ARVALID_IN && ARREADY_OUT && !ARRAY_MARGIN_OUT
    |-> ##[1:2] RVALID_OUT)
    else $error("plain read stretched");
  AST_WR_LAT: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
    |-> ##[1:2] BVALID_OUT)
    else $error("write response late");
  AST_RD_STROBE: assert property (ARRAY_READ_OUT |-> !RVALID_OUT)
    else $error("array read strobe overlaps read answer");
endmodule

/* test/tb_fpms_top.sv */
// self-checking bench of the flash program/margin sequencer
`include "fpms_regs.vh"
module tb_fpms_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, awv, wv, bry, arv, rry, wmode, smode, hv_pin;
  logic [7:0]  awa, ara, nv, ard;
  logic [31:0] wd, rd;
  logic [1:0]  rrsp;
  logic [63:0] page;
  wire         awr, wr_r, bv, arr, rv, pump, stby, prog, marg;
  wire  [1:0]  brsp, rrsp_w;
  wire  [31:0] rdat;
  wire  [14:0] aaddr;
  wire  [63:0] apage;
  wire  [7:0]  pwd;
  int          miscompares, n_tests, lat, lm;

  fpms_top u_fpms_top (.MCLK_IN(clk), .SRST_IN(rst), .AWADDR_IN(awa), .AWVALID_IN(awv),
    .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wr_r),
    .BRESP_OUT(brsp), .BVALID_OUT(bv), .BREADY_IN(bry), .ARADDR_IN(ara), .ARVALID_IN(arv),
    .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rrsp_w), .RVALID_OUT(rv),
    .RREADY_IN(rry), .WAIT_MODE_IN(wmode), .STOP_MODE_IN(smode),
    .ELEVATED_TEST_VOLTAGE_IN(hv_pin), .PROTECT_NV_IN(nv), .ARRAY_ADDR_OUT(aaddr),
    .ARRAY_PAGE_OUT(apage), .ARRAY_PROGRAM_OUT(prog), .ARRAY_MARGIN_OUT(marg),
    .ARRAY_READ_OUT(), .ARRAY_RDATA_IN(ard), .PROTECT_WRITE_OUT(), .PROTECT_WDATA_OUT(pwd),
    .CHARGE_PUMP_ON_OUT(pump), .STANDBY_OUT(stby), .WATCHDOG_TICK_OUT());

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // an expected response of all x means the response is not judged
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_r) wv <= 1'h0;
      if (bv) break;
    end
    if (n == 99) miscompares++;
    bry <= 1'h0;
    if (er !== 2'hx) chk(brsp, er);
  endtask

  task automatic rd_t(input logic [7:0] a);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk);
      if (arv && arr) begin
        arv <= 1'h0;
        lat = n;
      end
      if (rv) break;
    end
    if (n == 99) miscompares++;
    lat = n - lat;
    rd = rdat;
    rrsp = rrsp_w;
    rry <= 1'h0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd_t(a);
    chk(rd, exp);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // the whole sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  initial begin
    {rst, awv, wv, bry, arv, rry, wmode, smode, hv_pin} = 9'h100;
    {awa, ara, nv, ard, wd} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rc(`FPMS_CTRL_OFF, 32'h0);
    rd_t(8'h40);
    chk(rrsp, `FPMS_AXI_SLVERR);
    wr(`FPMS_PROTECT_OFF, 32'h5a, `FPMS_AXI_SLVERR);
    chk(pwd, 8'h00);
    hv_pin <= 1'h1;
    repeat (4) @(posedge clk);
    wr(`FPMS_PROTECT_OFF, 32'h5a, `FPMS_AXI_OKAY);
    chk(pwd, 8'h5a);
    // no interrupt source exists here, so programming runs undisturbed
    repeat (4) @(posedge clk);
    hv_pin <= 1'h0;
    wr(`FPMS_CTRL_OFF, 32'h1, `FPMS_AXI_OKAY);
    wr(`FPMS_CTRL_OFF, 32'h3, 2'hx);
    rc(`FPMS_CTRL_OFF, 32'h1);
    wr(`FPMS_CTRL_OFF, 32'h9, 2'hx);
    rc(`FPMS_CTRL_OFF, 32'h1);
    for (int i = 0; i < 8; i++) begin
      page[i*8+:8] = 8'h10 + 8'(i);
      wr(`FPMS_ADDR_OFF, 32'h1238 + 32'(i), `FPMS_AXI_OKAY);
      wr(`FPMS_DATA_OFF, {24'h0, page[i*8+:8]}, `FPMS_AXI_OKAY);
    end
    rc(`FPMS_PROTECT_OFF, 32'h0);
    rc(`FPMS_LATCH_LO_OFF, page[31:0]);
    rc(`FPMS_LATCH_HI_OFF, page[63:32]);
    chk(prog, 1'h0);
    wr(`FPMS_CTRL_OFF, 32'h9, `FPMS_AXI_OKAY);
    rc(`FPMS_CTRL_OFF, 32'h9);
    chk(prog, 1'h1);
    chk(aaddr, 15'h1238);
    chk(apage, page);
    wr(`FPMS_CTRL_OFF, 32'hd, 2'hx);
    rc(`FPMS_CTRL_OFF, 32'h9);
    for (int i = 0; i < 2; i++) begin
      {smode, wmode} <= (i == 0) ? 2'h1 : 2'h2;
      repeat (4) @(posedge clk);
      chk(pump, 1'h0);
      chk(stby, 1'h0);
      rc(`FPMS_CTRL_OFF, 32'h9);
      {smode, wmode} <= 2'h0;
      repeat (4) @(posedge clk);
      chk(pump, 1'h1);
    end
    wr(`FPMS_CTRL_OFF, 32'h1, `FPMS_AXI_OKAY);
    wr(`FPMS_CTRL_OFF, 32'h5, `FPMS_AXI_OKAY);
    rc(`FPMS_CTRL_OFF, 32'h5);
    wr(`FPMS_CTRL_OFF, 32'h4, `FPMS_AXI_OKAY);
    ard <= 8'ha5;
    rc(`FPMS_DATA_OFF, 32'ha5);
    lm = lat;
    wr(`FPMS_CTRL_OFF, 32'h0, `FPMS_AXI_OKAY);
    repeat (500) rd_t(`FPMS_DATA_OFF);
    ard <= `FPMS_ERASED_BYTE;
    rc(`FPMS_DATA_OFF, 32'h0);
    chk(64'(lm - lat), 64'h8);
    smode <= 1'h1;
    repeat (4) @(posedge clk);
    chk(stby, 1'h1);
    smode <= 1'h0;
    nv <= 8'h02;
    wr(`FPMS_CTRL_OFF, 32'h1, `FPMS_AXI_OKAY);
    wr(`FPMS_ADDR_OFF, 32'h1238, `FPMS_AXI_OKAY);
    wr(`FPMS_DATA_OFF, 32'h77, `FPMS_AXI_OKAY);
    rc(`FPMS_PROTECT_OFF, 32'h2);
    rc(`FPMS_CTRL_OFF, 32'h0);
    rd_t(`FPMS_STATUS_OFF);
    chk(rd[`FPMS_ST_BLOCKED], 1'h1);
    wr(`FPMS_CTRL_OFF, 32'h9, 2'hx);
    chk(pump, 1'h0);
    wrap_up();
  end
endmodule

bind fpms_top fpms_assertions u_fpms_assertions (.*);
